// file: verilog/eep_map.svh
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH

// ******************************************************
// geometry
// ******************************************************
`define EEP_DEPTH 2048
`define EEP_PAGE_BITS 4
`define EEP_PAGE_BYTES 16
`define EEP_BYTE_BITS 4'h8
`define EEP_CE_WIDTH 3

// ******************************************************
// select byte fields and transmit bit positions
// ******************************************************
`define EEP_SEL_CODE_HI 7
`define EEP_SEL_CODE_LO 4
`define EEP_SEL_CE_HI 3
`define EEP_SEL_CE_LO 1
`define EEP_SEL_RW 0
`define EEP_TX_MSB 7
`define EEP_TX_NEXT 6

// ******************************************************
// synchroniser lanes
// ******************************************************
`define EEP_PINS 7
`define EEP_PIN_SCL 0
`define EEP_PIN_SDA 1
`define EEP_PIN_CE0 2
`define EEP_PIN_CE2 4
`define EEP_PIN_WP 5
`define EEP_PIN_LOCK 6

// ******************************************************
// programming cycle timing
// ******************************************************
`define EEP_PROG_NS 5000
`define EEP_CLK_NS 5
`define EEP_CP_LAST 5'h10
`define EEP_CP_WAIT 5'h11

`endif

// file: verilog/eep_pkg.sv
package eep_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX = 6'h02,
		ST_ACK = 6'h04,
		ST_TX = 6'h08,
		ST_MACK = 6'h10,
		ST_PROG = 6'h20
	} eep_state_t;

	typedef enum logic [2:0] {
		ROLE_SEL = 3'h1,
		ROLE_ADDR = 3'h2,
		ROLE_DATA = 3'h4
	} eep_role_t;
endpackage

// file: verilog/eep_if.sv
`timescale 1ns/1ps
`default_nettype none

// ******************************************************
// memory port: one write port, one registered read port
// ******************************************************
interface eep_mem_if #(parameter int AW = 11);
	logic we;
	logic [AW-1:0] waddr;
	logic [7:0] wdata;
	logic [AW-1:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// ******************************************************
// programming request and completion, both as toggles
// ******************************************************
interface eep_prog_if;
	logic req_tgl;
	logic done_tgl;
	modport link (output req_tgl, input done_tgl);
	modport timer (input req_tgl, output done_tgl);
endinterface

`default_nettype wire

// file: verilog/eep_mem.sv
`timescale 1ns/1ps
`default_nettype none

module eep_mem
	import eep_pkg::*;
#(
	parameter int AW = 11
) (
	// clock
	input wire logic clk,
	// port
	eep_mem_if.mem m
);
	logic [7:0] cells [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (m.we) begin
			cells[m.waddr] <= m.wdata;
		end
	end

	// read data registered so the caller sees a clean one-cycle latency
	always_ff @(posedge clk) begin
		m.rdata <= cells[m.raddr];
	end
endmodule

`default_nettype wire

// file: verilog/eep_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "eep_map.svh"

module eep_timer
	import eep_pkg::*;
#(
	parameter int CYCLES = 1000
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// toggles to and from the link side
	eep_prog_if.timer p
);
	logic req_meta_q;
	logic req_sync_q;
	logic req_prev_q;
	logic busy_q;
	logic done_q;
	logic [15:0] cnt_q;

	// ******************************************************
	// request crossing from the link domain
	// ******************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_meta_q <= 1'b0;
			req_sync_q <= 1'b0;
			req_prev_q <= 1'b0;
		end else begin
			req_meta_q <= p.req_tgl;
			req_sync_q <= req_meta_q;
			req_prev_q <= req_sync_q;
		end
	end

	// ******************************************************
	// self-timed cycle
	// ******************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (!busy_q && (req_sync_q ^ req_prev_q)) begin
			busy_q <= 1'b1;
			cnt_q <= 16'(CYCLES - 1);
		end else if (busy_q) begin
			if (cnt_q == 16'h0000) begin
				busy_q <= 1'b0;
				done_q <= ~done_q;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end

	assign p.done_tgl = done_q;
endmodule

`default_nettype wire

// file: verilog/eep_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "eep_map.svh"

module eep_slave
	import eep_pkg::*;
#(
	parameter int DEPTH = `EEP_DEPTH,
	// value is arbitrary; set to the family code of the target bus
	parameter logic [3:0] DEV_CODE = 4'h5,
	parameter int PROG_CYCLES = (`EEP_PROG_NS + `EEP_CLK_NS - 1) /
		`EEP_CLK_NS
) (
	// system clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link sampling clock
	input wire logic link_clk,
	// two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// straps and control pins
	input wire logic chip_enable_bit0_input,
	input wire logic chip_enable_bit1_input,
	input wire logic chip_enable_bit2_input,
	input wire logic write_protect_input,
	input wire logic supply_low,
	// status
	output logic prog_busy
);
	localparam int AW = $clog2(DEPTH);

	// ******************************************************
	// declarations
	// ******************************************************
	logic lrst_meta_q;
	logic lrst_q;
	logic [`EEP_PINS-1:0] pin_raw;
	logic [`EEP_PINS-1:0] pin_meta_q;
	logic [`EEP_PINS-1:0] pin_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic done_meta_q;
	logic done_sync_q;
	logic done_prev_q;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic lock_s;
	logic [2:0] ce_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic done_edge;
	logic byte_end;
	logic pg_store;

	eep_state_t state_q;
	eep_role_t role_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic rw_q;
	logic wp_q;
	logic ack_q;
	logic mack_q;
	logic sda_low_q;
	logic [AW-1:0] addr_q;
	logic [`EEP_PAGE_BYTES-1:0] valid_q;
	logic [4:0] cp_q;
	logic req_q;
	logic [3:0] cp_idx;

	eep_mem_if #(.AW(AW)) arr_if ();
	eep_mem_if #(.AW(`EEP_PAGE_BITS)) pg_if ();
	eep_prog_if prog_if ();

	// ******************************************************
	// helpers
	// ******************************************************
	function automatic logic sel_match(input logic [7:0] b,
		input logic [2:0] ce, input logic [3:0] code);
		sel_match = (b[`EEP_SEL_CODE_HI:`EEP_SEL_CODE_LO] == code) &&
			(b[`EEP_SEL_CE_HI:`EEP_SEL_CE_LO] == ce);
	endfunction

	// ******************************************************
	// link reset: async assert, release on the link clock
	// ******************************************************
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lrst_meta_q <= 1'b1;
			lrst_q <= 1'b1;
		end else begin
			lrst_meta_q <= 1'b0;
			lrst_q <= lrst_meta_q;
		end
	end

	// ******************************************************
	// pin synchronisers
	// ******************************************************
	assign pin_raw = {supply_low, write_protect_input,
		chip_enable_bit2_input, chip_enable_bit1_input,
		chip_enable_bit0_input, sda_in, scl_in};

	genvar gi;
	generate
		for (gi = 0; gi < `EEP_PINS; gi++) begin : g_sync
			always_ff @(posedge link_clk or posedge lrst_q) begin
				if (lrst_q) begin
					// bus lanes rest high so release makes no false edge
					pin_meta_q[gi] <= (gi <= `EEP_PIN_SDA);
					pin_q[gi] <= (gi <= `EEP_PIN_SDA);
				end else begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate

	// lines idle high; history starts high so reset makes no false edge
	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_s = pin_q[`EEP_PIN_SCL] | lrst_q;
	assign sda_s = pin_q[`EEP_PIN_SDA] | lrst_q;
	// lane resets low, so an undriven protect leaves writes enabled
	assign wp_s = pin_q[`EEP_PIN_WP];
	assign lock_s = pin_q[`EEP_PIN_LOCK] | lrst_q;
	assign ce_s = pin_q[`EEP_PIN_CE2:`EEP_PIN_CE0];

	// bit timing derives from sampled clock edges; start and stop from sampled data edges while the clock is high
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ******************************************************
	// completion toggle from the timer
	// ******************************************************
	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			done_meta_q <= 1'b0;
			done_sync_q <= 1'b0;
			done_prev_q <= 1'b0;
		end else begin
			done_meta_q <= prog_if.done_tgl;
			done_sync_q <= done_meta_q;
			done_prev_q <= done_sync_q;
		end
	end

	assign done_edge = done_sync_q ^ done_prev_q;

	// ******************************************************
	// protocol engine
	// ******************************************************
	assign byte_end = (state_q == ST_RX) && scl_fall &&
		(cnt_q == `EEP_BYTE_BITS);
	// protected data never reaches the page buffer
	assign pg_store = byte_end && (role_q == ROLE_DATA) && !wp_q;

	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			state_q <= ST_IDLE;
			role_q <= ROLE_SEL;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			wp_q <= 1'b0;
			ack_q <= 1'b0;
			mack_q <= 1'b0;
			sda_low_q <= 1'b0;
			addr_q <= '0;
			valid_q <= '0;
			cp_q <= 5'h00;
			req_q <= 1'b0;
		end else if (lock_s && state_q != ST_PROG) begin
			state_q <= ST_IDLE;
			sda_low_q <= 1'b0;
			valid_q <= '0;
		end else if (state_q == ST_PROG) begin
			// bus ignored, start included, until the timer reports
			sda_low_q <= 1'b0;
			if (cp_q == `EEP_CP_LAST) begin
				req_q <= ~req_q;
				cp_q <= `EEP_CP_WAIT;
			end else if (cp_q != `EEP_CP_WAIT) begin
				cp_q <= cp_q + 5'h01;
			end else if (done_edge) begin
				state_q <= ST_IDLE;
				valid_q <= '0;
			end
		end else if (start_seen) begin
			// repeated start drops any unfinished page
			state_q <= ST_RX;
			role_q <= ROLE_SEL;
			cnt_q <= 4'h0;
			wp_q <= wp_s;
			sda_low_q <= 1'b0;
			valid_q <= '0;
		end else if (stop_seen) begin
			sda_low_q <= 1'b0;
			// the stop's own clock rise has already counted one bit
			if (state_q == ST_RX && role_q == ROLE_DATA &&
				cnt_q == 4'h1 && valid_q != '0) begin
				state_q <= ST_PROG;
				cp_q <= 5'h00;
			end else begin
				state_q <= ST_IDLE;
				valid_q <= '0;
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
					sda_low_q <= 1'b0;
				end
				ST_RX: begin
					if (role_q != ROLE_DATA) begin
						wp_q <= wp_q | wp_s;
					end
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (byte_end) begin
						case (role_q)
							ROLE_SEL: begin
								if (sel_match(sh_q, ce_s, DEV_CODE)) begin
									rw_q <= sh_q[`EEP_SEL_RW];
									ack_q <= 1'b1;
									sda_low_q <= 1'b1;
									state_q <= ST_ACK;
								end else begin
									state_q <= ST_IDLE;
								end
							end
							ROLE_ADDR: begin
								addr_q <= AW'(sh_q);
								ack_q <= 1'b1;
								sda_low_q <= 1'b1;
								state_q <= ST_ACK;
							end
							default: begin
								ack_q <= !wp_q;
								sda_low_q <= !wp_q;
								if (!wp_q) begin
									valid_q[addr_q[3:0]] <= 1'b1;
									addr_q <= {addr_q[AW-1:`EEP_PAGE_BITS],
										addr_q[3:0] + 4'h1};
								end
								state_q <= ST_ACK;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (role_q == ROLE_SEL && rw_q) begin
							// read from the current address
							tx_q <= arr_if.rdata;
							sda_low_q <= ~arr_if.rdata[`EEP_TX_MSB];
							state_q <= ST_TX;
						end else begin
							sda_low_q <= 1'b0;
							role_q <= (role_q == ROLE_SEL) ? ROLE_ADDR :
								ROLE_DATA;
							state_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == `EEP_BYTE_BITS) begin
							sda_low_q <= 1'b0;
							addr_q <= addr_q + AW'(1);
							state_q <= ST_MACK;
						end else begin
							sda_low_q <= ~tx_q[`EEP_TX_NEXT];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						if (mack_q) begin
							tx_q <= arr_if.rdata;
							sda_low_q <= ~arr_if.rdata[`EEP_TX_MSB];
							state_q <= ST_TX;
						end else begin
							// nack: wait for the closing stop
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
					sda_low_q <= 1'b0;
				end
			endcase
		end
	end

	// ******************************************************
	// page buffer and array
	// ******************************************************
	// copy runs one cycle behind the buffer read
	assign cp_idx = cp_q[3:0] - 4'h1;

	assign pg_if.we = pg_store;
	assign pg_if.waddr = addr_q[3:0];
	assign pg_if.wdata = sh_q;
	assign pg_if.raddr = cp_q[3:0];

	assign arr_if.we = (state_q == ST_PROG) && (cp_q != 5'h00) &&
		(cp_q <= `EEP_CP_LAST) && valid_q[cp_idx];
	assign arr_if.waddr = {addr_q[AW-1:`EEP_PAGE_BITS], cp_idx};
	assign arr_if.wdata = pg_if.rdata;
	assign arr_if.raddr = addr_q;

	eep_mem #(.AW(AW)) u_array (
		.clk(link_clk),
		.m(arr_if)
	);

	eep_mem #(.AW(`EEP_PAGE_BITS)) u_page (
		.clk(link_clk),
		.m(pg_if)
	);

	assign prog_if.req_tgl = req_q;

	eep_timer #(.CYCLES(PROG_CYCLES)) u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.p(prog_if)
	);

	// ******************************************************
	// outputs
	// ******************************************************
	// never drives high and never touches the clock line
	assign sda_out = 1'b0;
	assign sda_oe = sda_low_q;
	assign prog_busy = (state_q == ST_PROG);
endmodule

`default_nettype wire

// file: test/eep_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ******************************************************
// port checker for the serial memory slave
// ******************************************************
module eep_slave_asserts #(
	parameter int PROG_CYCLES = 1000
) (
	// clocks and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	// bus
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// control and status
	input wire logic supply_low,
	input wire logic prog_busy
);
	logic scl_q;
	logic [3:0] low_cnt_q;
	logic [15:0] busy_cnt_q;

	// link cycles since the bus clock last fell, zero while it is high
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			low_cnt_q <= 4'h0;
		end else begin
			scl_q <= scl_in;
			if (scl_in)
				low_cnt_q <= 4'h0;
			else if (scl_q)
				low_cnt_q <= 4'h1;
			else if (low_cnt_q != 4'hf)
				low_cnt_q <= low_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			busy_cnt_q <= 16'h0000;
		else if (!prog_busy)
			busy_cnt_q <= 16'h0000;
		else if (busy_cnt_q != 16'hffff)
			busy_cnt_q <= busy_cnt_q + 16'h0001;
	end

	a_out_low: assert property (
		@(posedge link_clk) disable iff (sys_rst) sda_out == 1'b0)
		else $error("sda_out not low");
	a_oe_in_low: assert property (
		@(posedge link_clk) disable iff (sys_rst)
		$changed(sda_oe) |-> low_cnt_q inside {[4'h1:4'h8]})
		else $error("sda_oe moved outside the clock low phase");
	a_lock_quiet: assert property (
		@(posedge link_clk) disable iff (sys_rst)
		supply_low [*8] |=> !$rose(sda_oe))
		else $error("data line pulled during lockout");
	a_busy_quiet: assert property (
		@(posedge clk) disable iff (sys_rst) prog_busy |-> !sda_oe)
		else $error("bus answered while programming");
	a_busy_short: assert property (
		@(posedge clk) disable iff (sys_rst)
		busy_cnt_q <= PROG_CYCLES + 60)
		else $error("programming cycle too long");
	a_busy_long: assert property (
		@(posedge clk) disable iff (sys_rst)
		$fell(prog_busy) |-> busy_cnt_q >= PROG_CYCLES - 2)
		else $error("programming cycle too short");
	a_busy_idle: assert property (
		@(posedge clk) disable iff (sys_rst)
		$rose(prog_busy) |-> scl_in && sda_in)
		else $error("programming began on a busy bus");
	a_reset_quiet: assert property (
		@(posedge link_clk) sys_rst && $past(sys_rst) |->
		!sda_oe && !prog_busy)
		else $error("outputs active in reset");
endmodule

bind eep_slave eep_slave_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_asserts (
	.clk(clk),
	.sys_rst(sys_rst),
	.link_clk(link_clk),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.supply_low(supply_low),
	.prog_busy(prog_busy)
);

`default_nettype wire

// file: test/eep_master.sv
`timescale 1ns/1ps
`default_nettype none

// ******************************************************
// bus master model, paced by the link clock
// ******************************************************
module eep_master (
	// link clock
	input wire logic link_clk,
	// resolved data line and master drives
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// bus clock parks high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask

	// also serves as repeated start from a low clock
	task automatic start();
		sda_low = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
	endtask

	task automatic stop();
		sda_low = 1'b1;
		tick(6);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b0;
		tick(4);
	endtask

	// data set in the low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		tick(6);
		scl = 1'b1;
		tick(5);
		r = sda;
		tick(5);
		scl = 1'b0;
		tick(2);
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// every byte acked except the last
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

`default_nettype wire

// file: test/eep_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

module eep_slave_tb;
	// value is arbitrary
	localparam logic [3:0] DEV = 4'h5;
	localparam int PROG = 1000;
	logic clk, link_clk, sys_rst, scl, sda, m_sda_low, sda_out, sda_oe;
	logic wp, supply_low, prog_busy;
	logic [2:0] ce;
	logic [7:0] rd_q[$];
	int n_errors = 0;
	int samples_checked = 0;

	// ******************************************************
	// wiring: open-drain data line with pull-up
	// ******************************************************
	assign sda = ~(m_sda_low | sda_oe);
	eep_master u_m (.link_clk(link_clk), .sda(sda), .scl(scl),
		.sda_low(m_sda_low));
	eep_slave #(.DEV_CODE(DEV), .PROG_CYCLES(PROG)) u_dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.link_clk(link_clk),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.chip_enable_bit0_input(ce[0]),
		.chip_enable_bit1_input(ce[1]),
		.chip_enable_bit2_input(ce[2]),
		.write_protect_input(wp),
		.supply_low(supply_low),
		.prog_busy(prog_busy)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3.7;
		forever #6 link_clk = ~link_clk;
	end

	// ******************************************************
	// shared tasks
	// ******************************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] sel(input logic rw);
		return {DEV, ce, rw};
	endfunction

	task automatic send(input logic [7:0] b, input logic exp);
		logic ack;
		u_m.wr_byte(b, ack);
		check("ack", {7'h00, exp}, {7'h00, ack});
	endtask

	task automatic write_seq(input logic [7:0] a, input logic [7:0] d[$],
		input logic dack);
		u_m.start();
		send(sel(1'b0), 1'b1);
		send(a, 1'b1);
		foreach (d[i])
			send(d[i], dack);
		u_m.stop();
	endtask

	task automatic read_seq(input logic [7:0] a, input int n);
		logic [7:0] d;
		rd_q.delete();
		u_m.start();
		send(sel(1'b0), 1'b1);
		send(a, 1'b1);
		u_m.start();
		send(sel(1'b1), 1'b1);
		for (int i = 0; i < n; i++) begin
			u_m.rd_byte(i == n - 1, d);
			rd_q.push_back(d);
		end
		u_m.stop();
	endtask

	// a start while busy must go unanswered
	task automatic wait_prog(input logic exp);
		int i;
		for (i = 0; i < 40 && prog_busy !== 1'b1; i++)
			u_m.tick(1);
		check("prog_busy", {7'h00, exp}, {7'h00, prog_busy});
		if (exp) begin
			u_m.start();
			send(sel(1'b0), 1'b0);
			u_m.stop();
		end
		for (i = 0; i < 600 && prog_busy !== 1'b0; i++)
			u_m.tick(1);
		if (prog_busy !== 1'b0) begin
			n_errors++;
			$display("unexpected prog_busy: expected 0 seen %b", prog_busy);
			end_sim();
		end
	endtask

	// ******************************************************
	// scenarios
	// ******************************************************
	task automatic t_page();
		write_seq(8'h3e, {8'ha5, 8'h3c, 8'h0f}, 1'b1);
		wait_prog(1'b1);
		read_seq(8'h3e, 2);
		check("read 3e", 8'ha5, rd_q[0]);
		check("read 3f", 8'h3c, rd_q[1]);
		read_seq(8'h30, 1);
		check("read 30", 8'h0f, rd_q[0]);
		$display("test page done");
	endtask

	task automatic t_select();
		for (int k = 0; k < 8; k++) begin
			ce = k[2:0];
			u_m.start();
			send(sel(1'b0), 1'b1);
			u_m.stop();
			u_m.start();
			send({DEV, ~ce, 1'b0}, 1'b0);
			u_m.stop();
			u_m.start();
			send({~DEV, ce, 1'b0}, 1'b0);
			send(8'h00, 1'b0);
			u_m.stop();
		end
		$display("test select done");
	endtask

	task automatic t_protect();
		wp = 1'b1;
		write_seq(8'h3e, {8'h77, 8'h66}, 1'b0);
		wait_prog(1'b0);
		wp = 1'b0;
		u_m.start();
		send(sel(1'b0), 1'b1);
		send(8'h3e, 1'b1);
		u_m.stop();
		wait_prog(1'b0);
		read_seq(8'h3e, 1);
		check("read 3e", 8'ha5, rd_q[0]);
		$display("test protect done");
	endtask

	task automatic t_lock();
		supply_low = 1'b1;
		u_m.tick(10);
		u_m.start();
		send(sel(1'b0), 1'b0);
		u_m.stop();
		supply_low = 1'b0;
		u_m.tick(10);
		u_m.start();
		send(sel(1'b0), 1'b1);
		u_m.stop();
		$display("test lockout done");
	endtask

	initial begin
		sys_rst = 1'b1;
		ce = 3'b000;
		wp = 1'b0;
		supply_low = 1'b0;
		// longer than two cycles so the link side sees reset too
		repeat (8) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		u_m.tick(10);
		t_page();
		t_select();
		t_protect();
		t_lock();
		end_sim();
	end
endmodule

`default_nettype wire
